// ### essei_regs.svh
// Register map, field positions, reset values and timing counts.
`ifndef ESSEI_REGS_SVH
`define ESSEI_REGS_SVH

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define ESSEI_CLK_PERIOD_NS  100
`define ESSEI_MIN_PULSE_NS   500
`define ESSEI_MIN_PULSE_CYC  \
   ((`ESSEI_MIN_PULSE_NS + `ESSEI_CLK_PERIOD_NS - 1) / `ESSEI_CLK_PERIOD_NS)
`define ESSEI_LOCKOUT_MS     100
`define ESSEI_LOCKOUT_CYC    \
   (`ESSEI_LOCKOUT_MS * 1000000 / `ESSEI_CLK_PERIOD_NS)
`define ESSEI_FILT0_NS       0
`define ESSEI_FILT1_NS       500
`define ESSEI_FILT2_NS       1000
`define ESSEI_FILT3_NS       2000
`define ESSEI_FILT4_NS       5000
`define ESSEI_FILT5_NS       10000
`define ESSEI_COMP_MAX_NS    2000
`define ESSEI_NS2CYC(ns)     ((ns) / `ESSEI_CLK_PERIOD_NS)
`define ESSEI_COMP_CYC       `ESSEI_NS2CYC(`ESSEI_COMP_MAX_NS)

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define ESSEI_OFS_CTRL       12'h000
`define ESSEI_OFS_WIDTH      12'h004
`define ESSEI_OFS_STATUS     12'h008
`define ESSEI_OFS_MASK       12'h00C
`define ESSEI_OFS_STATE      12'h010
`define ESSEI_OFS_CMD        12'h014

// ---------------------------------------------------------------
// Fields and reset values
// ---------------------------------------------------------------
`define ESSEI_CTRL_START_LSB 0
`define ESSEI_CTRL_STOP_LSB  2
`define ESSEI_CTRL_FUNC_BIT  4
`define ESSEI_CTRL_FILT_LSB  8
`define ESSEI_CTRL_RESET     32'h0000_0000
`define ESSEI_WIDTH_BITS     16
`define ESSEI_ST_START       0
`define ESSEI_ST_STOP        1
`define ESSEI_ST_CYCLE       2
`define ESSEI_ST_ARM         3
`define ESSEI_ST_REJECT      4
`define ESSEI_ST_BITS        5
`define ESSEI_CMD_ACQ_BIT    0

`endif

// ### essei_pkg.sv
// Types shared by the start, stop and event input conditioner.
package essei_pkg;

   typedef enum logic [1:0] {
      ESSEI_EDGE_OFF  = 2'h0,
      ESSEI_EDGE_RISE = 2'h1,
      ESSEI_EDGE_FALL = 2'h2
   } essei_edge_t;

   typedef enum logic {
      ESSEI_FUNC_CYCLE = 1'h0,
      ESSEI_FUNC_ARM   = 1'h1
   } essei_func_t;

   typedef enum logic [2:0] {
      ESSEI_Q_IDLE = 3'h1,
      ESSEI_Q_MEAS = 3'h2,
      ESSEI_Q_HOLD = 3'h4
   } essei_qstate_t;

endpackage

// ### essei_pulse_qual.sv
// Edge select, pulse-width qualifier and lockout for one input.
`timescale 1ns/1ps
`default_nettype none
`include "essei_regs.svh"
module essei_pulse_qual
   import essei_pkg::*;
#(
   parameter int unsigned LOCKOUT_CYC = `ESSEI_LOCKOUT_CYC
) (
   // Clock and reset
   input  wire logic        i_clk_sys,
   input  wire logic        i_reset,
   // Pin and configuration
   input  wire logic        i_pin,
   input  wire logic [1:0]  i_mode,
   input  wire logic [15:0] i_width,
   // Results
   output logic             o_accept,
   output logic             o_reject,
   output logic             o_locked,
   output logic             o_level
);
   logic          sync1_reg;
   logic          prev_act_reg;
   logic [15:0]   cnt_reg;
   logic [31:0]   lock_reg;
   essei_qstate_t state_reg;
   logic          enabled;
   logic          act;
   logic [15:0]   eff_width;

   assign enabled   = (i_mode == ESSEI_EDGE_RISE) ||
                      (i_mode == ESSEI_EDGE_FALL);
   assign act       = (i_mode == ESSEI_EDGE_FALL) ? ~o_level : o_level;
   assign eff_width = (i_width == 16'h0000) ? 16'h0001 : i_width;
   assign o_locked  = (lock_reg != 32'h0000_0000);

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         sync1_reg <= 1'b1;
         o_level   <= 1'b1;
      end else begin
         sync1_reg <= i_pin;
         o_level   <= sync1_reg;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         state_reg    <= ESSEI_Q_IDLE;
         cnt_reg      <= 16'h0000;
         prev_act_reg <= 1'b1;
         o_accept     <= 1'b0;
         o_reject     <= 1'b0;
      end else begin
         prev_act_reg <= act;
         o_accept     <= 1'b0;
         o_reject     <= 1'b0;
         case (state_reg)
            ESSEI_Q_IDLE: begin
               if (enabled && act && !prev_act_reg) begin
                  state_reg <= ESSEI_Q_MEAS;
                  cnt_reg   <= 16'h0001;
               end
            end
            ESSEI_Q_MEAS: begin
               if (!enabled) begin
                  state_reg <= ESSEI_Q_IDLE;
               end else if (!act) begin
                  state_reg <= ESSEI_Q_IDLE;
                  o_reject  <= 1'b1;
               end else if (cnt_reg + 16'h0001 >= eff_width) begin
                  state_reg <= ESSEI_Q_HOLD;
                  o_accept  <= !o_locked;
               end else begin
                  cnt_reg <= cnt_reg + 16'h0001;
               end
            end
            ESSEI_Q_HOLD: begin
               if (!enabled || !act) begin
                  state_reg <= ESSEI_Q_IDLE;
               end
            end
            default: state_reg <= ESSEI_Q_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         lock_reg <= 32'h0000_0000;
      end else if (o_accept) begin
         lock_reg <= LOCKOUT_CYC - 1;
      end else if (o_locked) begin
         lock_reg <= lock_reg - 32'h0000_0001;
      end
   end

   property p_sync_two_stage;
      @(posedge i_clk_sys) disable iff (i_reset)
      $past(!i_reset, 2) |-> o_level == $past(i_pin, 2);
   endproperty
   a_sync_two_stage: assert property (p_sync_two_stage)
      else $error("Input level is not delayed by two flops.");

   property p_disabled_silent;
      @(posedge i_clk_sys) disable iff (i_reset)
      (!enabled && $past(!enabled)) |-> !o_accept;
   endproperty
   a_disabled_silent: assert property (p_disabled_silent)
      else $error("Event accepted from a disabled input.");

   property p_width_met;
      @(posedge i_clk_sys) disable iff (i_reset)
      o_accept |-> $past(state_reg) == ESSEI_Q_MEAS
                   && $past(cnt_reg) + 16'h0001 >= $past(eff_width)
                   && $past(act);
   endproperty
   a_width_met: assert property (p_width_met)
      else $error("Event accepted before the pulse width was met.");

   property p_lockout;
      @(posedge i_clk_sys) disable iff (i_reset)
      o_accept |-> $past(lock_reg) == 32'h0000_0000
                   ##1 lock_reg == LOCKOUT_CYC - 1;
   endproperty
   a_lockout: assert property (p_lockout)
      else $error("Lockout not respected or not restarted.");

   property p_edge_starts;
      @(posedge i_clk_sys) disable iff (i_reset)
      (state_reg == ESSEI_Q_IDLE && enabled && act && !prev_act_reg)
         |=> state_reg == ESSEI_Q_MEAS && cnt_reg == 16'h0001;
   endproperty
   a_edge_starts: assert property (p_edge_starts)
      else $error("Selected edge did not start a measurement.");
endmodule
`default_nettype wire

// ### essei_top.sv
// Start, stop and event input conditioner with APB registers.
`timescale 1ns/1ps
`default_nettype none
`include "essei_regs.svh"
module essei_top
   import essei_pkg::*;
#(
   parameter int unsigned LOCKOUT_CYC = `ESSEI_LOCKOUT_CYC
) (
   // Clock and reset
   input  wire logic        i_clk_sys,
   input  wire logic        i_reset,
   // APB slave
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [11:0] i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic [31:0]      o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   // External pins
   input  wire logic        i_ext_start,
   input  wire logic        i_ext_stop,
   input  wire logic        i_ext_event,
   // Conditioned events
   output logic             o_start_req,
   output logic             o_stop_req,
   output logic             o_cycle_event,
   output logic             o_trig_arm,
   output logic             o_irq
);
   localparam int unsigned COMP = `ESSEI_COMP_CYC;

   // ---------------------------------------------------------------
   // Registers and wires
   // ---------------------------------------------------------------
   logic [31:0]               ctrl_reg;
   logic [15:0]               width_reg;
   logic [`ESSEI_ST_BITS-1:0] status_reg;
   logic [`ESSEI_ST_BITS-1:0] mask_reg;
   logic [`ESSEI_ST_BITS-1:0] status_set;
   logic                      start_pend_reg;
   logic                      stop_pend_reg;
   logic                      ev_sync1_reg;
   logic                      ev_sync2_reg;
   logic [COMP-1:0]           line_reg;
   logic                      filt_lvl_reg;
   logic                      filt_prev_reg;
   logic [6:0]                deb_cnt_reg;
   logic [6:0]                filt_cyc;
   logic [4:0]                tap;
   logic                      dly;
   logic                      ev_edge;
   logic                      start_acc;
   logic                      stop_acc;
   logic                      start_rej;
   logic                      stop_rej;
   logic                      start_locked;
   logic                      stop_locked;
   logic                      start_lvl;
   logic                      stop_lvl;
   logic                      wr_en;
   logic                      rd_en;
   logic                      acq_started;
   logic                      addr_ok;
   essei_func_t               func;

   assign func = essei_func_t'(ctrl_reg[`ESSEI_CTRL_FUNC_BIT]);

   // ---------------------------------------------------------------
   // Start and stop channels
   // ---------------------------------------------------------------
   essei_pulse_qual #(
      .LOCKOUT_CYC (LOCKOUT_CYC)
   ) u_start (
      .i_clk_sys (i_clk_sys),
      .i_reset   (i_reset),
      .i_pin     (i_ext_start),
      .i_mode    (ctrl_reg[`ESSEI_CTRL_START_LSB +: 2]),
      .i_width   (width_reg),
      .o_accept  (start_acc),
      .o_reject  (start_rej),
      .o_locked  (start_locked),
      .o_level   (start_lvl)
   );

   essei_pulse_qual #(
      .LOCKOUT_CYC (LOCKOUT_CYC)
   ) u_stop (
      .i_clk_sys (i_clk_sys),
      .i_reset   (i_reset),
      .i_pin     (i_ext_stop),
      .i_mode    (ctrl_reg[`ESSEI_CTRL_STOP_LSB +: 2]),
      .i_width   (width_reg),
      .o_accept  (stop_acc),
      .o_reject  (stop_rej),
      .o_locked  (stop_locked),
      .o_level   (stop_lvl)
   );

   // ---------------------------------------------------------------
   // APB slave
   // ---------------------------------------------------------------
   assign addr_ok = (i_paddr == `ESSEI_OFS_CTRL)  ||
                    (i_paddr == `ESSEI_OFS_WIDTH) ||
                    (i_paddr == `ESSEI_OFS_STATUS) ||
                    (i_paddr == `ESSEI_OFS_MASK)  ||
                    (i_paddr == `ESSEI_OFS_STATE) ||
                    (i_paddr == `ESSEI_OFS_CMD);
   assign wr_en = i_psel && i_penable && o_pready && i_pwrite && addr_ok;
   assign rd_en = i_psel && i_penable && !o_pready && !i_pwrite;
   assign acq_started = wr_en && (i_paddr == `ESSEI_OFS_CMD)
                        && i_pwdata[`ESSEI_CMD_ACQ_BIT];

   // One wait state: ready and read data are both registered.
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         o_pready  <= 1'b0;
         o_pslverr <= 1'b0;
      end else begin
         o_pready  <= i_psel && i_penable && !o_pready;
         o_pslverr <= i_psel && i_penable && !o_pready && !addr_ok;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         o_prdata <= 32'h0000_0000;
      end else if (rd_en) begin
         if (i_paddr == `ESSEI_OFS_CTRL) begin
            o_prdata <= ctrl_reg;
         end else if (i_paddr == `ESSEI_OFS_WIDTH) begin
            o_prdata <= {16'h0000, width_reg};
         end else if (i_paddr == `ESSEI_OFS_STATUS) begin
            o_prdata <= {27'h0000000, status_reg};
         end else if (i_paddr == `ESSEI_OFS_MASK) begin
            o_prdata <= {27'h0000000, mask_reg};
         end else if (i_paddr == `ESSEI_OFS_STATE) begin
            o_prdata <= {25'h0000000, stop_pend_reg, start_pend_reg,
                         stop_locked, start_locked,
                         filt_lvl_reg, stop_lvl, start_lvl};
         end else begin
            o_prdata <= 32'h0000_0000;
         end
      end else begin
         o_prdata <= 32'h0000_0000;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         ctrl_reg  <= `ESSEI_CTRL_RESET;
         width_reg <= 16'(`ESSEI_MIN_PULSE_CYC);
         mask_reg  <= '0;
      end else if (wr_en) begin
         if (i_paddr == `ESSEI_OFS_CTRL) begin
            ctrl_reg <= i_pwdata & 32'h0000_071F;
         end else if (i_paddr == `ESSEI_OFS_WIDTH) begin
            width_reg <= i_pwdata[15:0];
         end else if (i_paddr == `ESSEI_OFS_MASK) begin
            mask_reg <= i_pwdata[`ESSEI_ST_BITS-1:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // Interrupt status
   // ---------------------------------------------------------------
   always_comb begin
      status_set = '0;
      status_set[`ESSEI_ST_START]  = start_acc;
      status_set[`ESSEI_ST_STOP]   = stop_acc;
      status_set[`ESSEI_ST_CYCLE]  = ev_edge && func == ESSEI_FUNC_CYCLE;
      status_set[`ESSEI_ST_ARM]    = ev_edge && func == ESSEI_FUNC_ARM;
      status_set[`ESSEI_ST_REJECT] = start_rej || stop_rej;
   end

   // Software handles these events; the set wins over a clear.
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         status_reg <= '0;
         o_irq      <= 1'b0;
      end else begin
         if (wr_en && i_paddr == `ESSEI_OFS_STATUS) begin
            status_reg <= (status_reg & ~i_pwdata[`ESSEI_ST_BITS-1:0])
                          | status_set;
         end else begin
            status_reg <= status_reg | status_set;
         end
         o_irq <= |(status_reg & mask_reg);
      end
   end

   // ---------------------------------------------------------------
   // Start and stop requests
   // ---------------------------------------------------------------
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         start_pend_reg <= 1'b0;
         stop_pend_reg  <= 1'b0;
         o_start_req    <= 1'b0;
         o_stop_req     <= 1'b0;
      end else begin
         o_start_req <= start_acc;
         o_stop_req  <= 1'b0;
         if (start_acc) begin
            start_pend_reg <= 1'b1;
         end else if (acq_started) begin
            start_pend_reg <= 1'b0;
         end
         if (stop_acc && (start_pend_reg || start_acc)) begin
            stop_pend_reg <= 1'b1;
         end else if (stop_acc) begin
            o_stop_req <= 1'b1;
         end else if (stop_pend_reg && !start_pend_reg) begin
            stop_pend_reg <= 1'b0;
            o_stop_req    <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Event input: debounce with delay compensation
   // ---------------------------------------------------------------
   always_comb begin
      case (ctrl_reg[`ESSEI_CTRL_FILT_LSB +: 3])
         3'h1:    filt_cyc = 7'(`ESSEI_NS2CYC(`ESSEI_FILT1_NS));
         3'h2:    filt_cyc = 7'(`ESSEI_NS2CYC(`ESSEI_FILT2_NS));
         3'h3:    filt_cyc = 7'(`ESSEI_NS2CYC(`ESSEI_FILT3_NS));
         3'h4:    filt_cyc = 7'(`ESSEI_NS2CYC(`ESSEI_FILT4_NS));
         3'h5:    filt_cyc = 7'(`ESSEI_NS2CYC(`ESSEI_FILT5_NS));
         default: filt_cyc = 7'(`ESSEI_NS2CYC(`ESSEI_FILT0_NS));
      endcase
   end

   // A fixed base delay hides short filters; longer ones keep the excess.
   always_comb begin
      if (filt_cyc >= 7'(COMP)) begin
         tap = 5'h00;
      end else if (filt_cyc == 7'h00) begin
         // A zero filter still costs the debounce flop one cycle.
         tap = 5'(7'(COMP) - 7'h01);
      end else begin
         tap = 5'(7'(COMP) - filt_cyc);
      end
      dly = (tap == 5'h00) ? ev_sync2_reg : line_reg[tap - 5'h01];
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         ev_sync1_reg <= 1'b1;
         ev_sync2_reg <= 1'b1;
         line_reg     <= '1;
      end else begin
         ev_sync1_reg <= i_ext_event;
         ev_sync2_reg <= ev_sync1_reg;
         line_reg     <= {line_reg[COMP-2:0], ev_sync2_reg};
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         filt_lvl_reg  <= 1'b1;
         filt_prev_reg <= 1'b1;
         deb_cnt_reg   <= 7'h00;
      end else begin
         filt_prev_reg <= filt_lvl_reg;
         if (dly == filt_lvl_reg) begin
            deb_cnt_reg <= 7'h00;
         end else if (deb_cnt_reg + 7'h01 >= filt_cyc) begin
            filt_lvl_reg <= dly;
            deb_cnt_reg  <= 7'h00;
         end else begin
            deb_cnt_reg <= deb_cnt_reg + 7'h01;
         end
      end
   end

   // The pin idles high on its pull-up; a short to ground is the event.
   assign ev_edge = filt_prev_reg && !filt_lvl_reg;

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         o_cycle_event <= 1'b0;
         o_trig_arm    <= 1'b0;
      end else begin
         o_cycle_event <= ev_edge && func == ESSEI_FUNC_CYCLE;
         o_trig_arm    <= ev_edge && func == ESSEI_FUNC_ARM;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   property p_filter_stable;
      @(posedge i_clk_sys) disable iff (i_reset)
      $changed(filt_lvl_reg) |->
         $past(deb_cnt_reg) + 7'h01 >= $past(filt_cyc)
         && $past(dly) != $past(filt_lvl_reg);
   endproperty
   a_filter_stable: assert property (p_filter_stable)
      else $error("Filtered level moved before the debounce time.");

   property p_compensation;
      @(posedge i_clk_sys) disable iff (i_reset)
      (filt_cyc <= 7'(COMP)) |-> 7'(tap) + filt_cyc
         + ((filt_cyc == 7'h00) ? 7'h01 : 7'h00) == 7'(COMP);
   endproperty
   a_compensation: assert property (p_compensation)
      else $error("Base delay does not hide the short filter.");

   property p_func_select;
      @(posedge i_clk_sys) disable iff (i_reset)
      ev_edge |=> (o_cycle_event == ($past(func) == ESSEI_FUNC_CYCLE))
                  && (o_trig_arm == ($past(func) == ESSEI_FUNC_ARM));
   endproperty
   a_func_select: assert property (p_func_select)
      else $error("Event routed to the wrong function.");

   property p_stop_after_start;
      @(posedge i_clk_sys) disable iff (i_reset)
      (stop_acc && start_pend_reg && !acq_started) |=>
         !o_stop_req && stop_pend_reg;
   endproperty
   a_stop_after_start: assert property (p_stop_after_start)
      else $error("Stop not held until the acquisition started.");

   property p_stop_release;
      @(posedge i_clk_sys) disable iff (i_reset)
      (stop_pend_reg && !start_pend_reg && !stop_acc) |=> o_stop_req;
   endproperty
   a_stop_release: assert property (p_stop_release)
      else $error("Held stop not issued after acquisition start.");

   property p_irq_level;
      @(posedge i_clk_sys) disable iff (i_reset)
      $past(!i_reset) |-> o_irq == |($past(status_reg) & $past(mask_reg));
   endproperty
   a_irq_level: assert property (p_irq_level)
      else $error("Interrupt does not follow masked status.");
endmodule
`default_nettype wire

// ### essei_pin_src.sv
// Model of the external TTL sources on the start, stop and event pins.
`timescale 1ns/1ps
`default_nettype none
module essei_pin_src (
   // Clock
   input  wire logic i_clk_sys,
   // Pins, index 0 start, 1 stop, 2 event
   output logic [2:0] o_pin
);
   // The pins idle high, as the pull-ups on the connector hold them.
   initial o_pin = 3'h7;
   // Drives one pin to a level for n cycles, then back to the other level.
   task automatic pulse(input int k, input logic v, input int n);
      @(posedge i_clk_sys);
      o_pin[k] <= v;
      repeat (n) @(posedge i_clk_sys);
      o_pin[k] <= ~v;
   endtask
endmodule
`default_nettype wire

// ### essei_top_tb_top.sv
// Self-checking bench for the start, stop and event input conditioner.
`timescale 1ns/1ps
`default_nettype none
`include "essei_regs.svh"
module essei_top_tb_top;
   import essei_pkg::*;
   localparam logic [11:0] CT = `ESSEI_OFS_CTRL;
   localparam logic [11:0] WD = `ESSEI_OFS_WIDTH;
   localparam logic [11:0] ST = `ESSEI_OFS_STATUS;
   localparam logic [11:0] MK = `ESSEI_OFS_MASK;
   localparam logic [11:0] CM = `ESSEI_OFS_CMD;
   logic        clk, rst, psel, pen, pwr, rdy, perr;
   logic        sreq, preq, cyc, arm, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, pe;
   logic [2:0]  pin;
   int          num_errors, num_checks, ns, np, nc, na, i, b;
   int          lat[6];
   essei_top #(.LOCKOUT_CYC(200)) u_essei_top (.i_clk_sys(clk),
      .i_reset(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
      .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(rdy), .o_pslverr(perr), .i_ext_start(pin[0]),
      .i_ext_stop(pin[1]), .i_ext_event(pin[2]), .o_start_req(sreq),
      .o_stop_req(preq), .o_cycle_event(cyc), .o_trig_arm(arm),
      .o_irq(irq));
   essei_pin_src u_essei_pin_src (.i_clk_sys(clk), .o_pin(pin));
   initial begin
      clk = 0;
      forever #50 clk = ~clk;
   end
   // Counts the one-cycle pulses of the start, stop, cycle and arm outputs.
   always @(posedge clk) begin
      ns += (sreq === 1'b1);
      np += (preq === 1'b1);
      nc += (cyc === 1'b1);
      na += (arm === 1'b1);
   end
   task results;
      if (num_errors == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         num_errors++;
         $display("BAD %0t got %h expected %h", $time, g, e);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (rdy !== 1'b1 && n < 20);
      if (n >= 20) begin
         num_errors++;
         results;
      end
      rd = prdata;
      pe = {31'h0, perr};
      psel <= 0;
      pen <= 0;
   endtask
   task pls(input int k, input int n, input int w);
      u_essei_pin_src.pulse(k, 1'b0, n);
      repeat (w) @(posedge clk);
   endtask
   task s_regs;
      apb(0, WD, 0);
      chk(rd, 32'h5);
      apb(0, 12'hFF0, 0);
      chk(pe, 32'h1);
   endtask
   task s_modes;
      logic [31:0] c[6];
      logic [7:0]  es[6], ep[6];
      c = '{32'h0, 32'h1, 32'h2, 32'h4, 32'h8, 32'hC};
      es = '{8'h0, 8'h1, 8'h2, 8'h2, 8'h2, 8'h2};
      ep = '{8'h0, 8'h0, 8'h0, 8'h1, 8'h2, 8'h2};
      for (i = 0; i < 6; i++) begin
         apb(1, CT, c[i]);
         apb(1, CM, 32'h1);
         pls(i / 3, 5, 250);
         chk({ns[7:0], np[7:0]}, {es[i], ep[i]});
      end
   endtask
   task s_width;
      b = ns;
      apb(1, CT, 32'h2);
      apb(1, ST, 32'h1F);
      pls(0, 4, 30);
      apb(0, ST, 0);
      chk(rd, 32'h10);
      apb(1, WD, 32'h8);
      pls(0, 7, 30);
      chk(ns - b, 0);
      pls(0, 8, 30);
      chk(ns - b, 1);
      pls(0, 8, 250);
      chk(ns - b, 1);
      pls(0, 8, 250);
      chk(ns - b, 2);
   endtask
   task s_hold;
      apb(1, CT, 32'hA);
      apb(1, CM, 32'h1);
      b = np;
      pls(0, 8, 0);
      pls(1, 8, 40);
      chk(np - b, 0);
      apb(1, CM, 32'h1);
      repeat (5) @(posedge clk);
      chk(np - b, 1);
   endtask
   task s_event;
      int ex[6];
      ex = '{0, 0, 0, 0, 30, 80};
      for (i = 0; i < 6; i++) begin
         apb(1, CT, i << 8);
         fork
            u_essei_pin_src.pulse(2, 1'b0, 150);
            begin
               lat[i] = 0;
               do begin
                  @(posedge clk);
                  lat[i]++;
               end while (cyc !== 1'b1 && lat[i] < 400);
            end
         join
         if (lat[i] >= 400) begin
            num_errors++;
            results;
         end
         repeat (250) @(posedge clk);
         chk(lat[i] - lat[0], ex[i]);
      end
      apb(1, CT, 32'h10);
      pls(2, 20, 80);
      chk({nc[7:0], na[7:0]}, {8'h6, 8'h1});
   endtask
   task s_irq;
      apb(1, CT, 32'h2);
      apb(1, ST, 32'h1F);
      apb(1, MK, 32'h0);
      pls(0, 8, 40);
      chk(irq, 1'b0);
      apb(1, MK, 32'h1);
      repeat (3) @(posedge clk);
      chk(irq, 1'b1);
      apb(1, ST, 32'h1);
      repeat (3) @(posedge clk);
      chk(irq, 1'b0);
   endtask
   initial begin
      rst = 1;
      psel = 0;
      pen = 0;
      pwr = 0;
      paddr = 0;
      pwdata = 0;
      repeat (6) @(posedge clk);
      rst <= 0;
      s_regs;
      s_modes;
      s_width;
      s_hold;
      s_event;
      s_irq;
      results;
   end
endmodule
`default_nettype wire
